// >>> jtb_pkg.sv
`default_nettype none
package jtb_pkg;

  localparam int NUM_PINS = 4;
  localparam int IR_W     = 10;
  localparam int CELL_IN  = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE  = 2;
  localparam int CELL_W   = 3;
  localparam int BSR_W    = NUM_PINS * CELL_W;

  // fixed capture value, shifts out lsb first as 1,0,1,0...
  localparam logic [IR_W-1:0] IR_CAPTURE = 10'h155;
  localparam logic [IR_W-1:0] IR_BYPASS  = 10'h3FF;
  // instruction codes below are arbitrary
  localparam logic [IR_W-1:0] IR_EXTEST  = 10'h00F;
  localparam logic [IR_W-1:0] IR_SAMPLE  = 10'h005;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } jtb_tap_state_t;

  // levels arriving from outside the tck domain
  typedef struct packed {
    logic                rst_n;
    logic                prog;
    logic                configured;
    logic                force_ibuf;
    logic [NUM_PINS-1:0] out_only;
    logic [NUM_PINS-1:0] pin;
  } jtb_async_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] oe_n;
    logic [NUM_PINS-1:0] out;
  } jtb_upd_t;

  typedef struct packed {
    logic extest;
    logic tog;
  } jtb_xing_t;

  function automatic jtb_tap_state_t tap_next(input jtb_tap_state_t s,
                                              input logic tms);
    jtb_tap_state_t n;
    n = s;
    unique case (s)
      TLR:    n = tms ? TLR    : RTI;
      RTI:    n = tms ? SEL_DR : RTI;
      SEL_DR: n = tms ? SEL_IR : CAP_DR;
      CAP_DR: n = tms ? EX1_DR : SH_DR;
      SH_DR:  n = tms ? EX1_DR : SH_DR;
      EX1_DR: n = tms ? UPD_DR : PA_DR;
      PA_DR:  n = tms ? EX2_DR : PA_DR;
      EX2_DR: n = tms ? UPD_DR : SH_DR;
      UPD_DR: n = tms ? SEL_DR : RTI;
      SEL_IR: n = tms ? TLR    : CAP_IR;
      CAP_IR: n = tms ? EX1_IR : SH_IR;
      SH_IR:  n = tms ? EX1_IR : SH_IR;
      EX1_IR: n = tms ? UPD_IR : PA_IR;
      PA_IR:  n = tms ? EX2_IR : PA_IR;
      EX2_IR: n = tms ? UPD_IR : SH_IR;
      UPD_IR: n = tms ? SEL_DR : RTI;
    endcase
    return n;
  endfunction

  function automatic logic [NUM_PINS-1:0] bsr_inputs(
      input logic [BSR_W-1:0] b);
    logic [NUM_PINS-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      v[i] = b[i*CELL_W+CELL_IN];
    end
    return v;
  endfunction

endpackage
`default_nettype wire

// >>> jtb_tap.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// R01: output-only pins read zero when configured
// R02: force option keeps every input buffer on
// R03: scan logic enabled at every power-up
// R04: scan port dedicated, never disabled
// R05: master idles with tms,tdi high, tck low
// R06: capture pattern appears on first shift-ir cycle
// R07: master reaches shift-ir via 0,1,1,0,0
// R08: master preloads before first extest
// R09: extest drives update value when enable zero
// R10: extest and sample barred during programming
// R11: extest pins come from update registers
// R12: all-ones selects one-bit bypass path
// R13: sixteen-state controller, five tms-high resets
module jtb_tap (
  input  wire  logic                          clk_sys,
  input  wire  logic                          rst_n,
  input  wire  logic                          tck,
  input  wire  logic                          tms,
  input  wire  logic                          tdi,
  output logic                                tdo,
  output logic                                tdo_oe_n,
  input  wire  logic                          in_system_programming,
  input  wire  logic                          configured,
  input  wire  logic                          force_input_buffers,
  input  wire  logic [jtb_pkg::NUM_PINS-1:0]  pin_output_only,
  input  wire  logic [jtb_pkg::NUM_PINS-1:0]  core_out,
  input  wire  logic [jtb_pkg::NUM_PINS-1:0]  core_oe_n,
  input  wire  logic [jtb_pkg::NUM_PINS-1:0]  pin_i,
  output logic [jtb_pkg::NUM_PINS-1:0]        pin_o,
  output logic [jtb_pkg::NUM_PINS-1:0]        pin_oe_n
);
  jtb_pkg::jtb_async_t         async_in;
  jtb_pkg::jtb_async_t         as1_r;
  jtb_pkg::jtb_async_t         as2_r;
  jtb_pkg::jtb_async_t         as3_r;
  jtb_pkg::jtb_async_t         asf_r;
  logic                        tck_rst;
  jtb_pkg::jtb_tap_state_t     st_r;
  logic [jtb_pkg::IR_W-1:0]    ir_sr_r;
  logic [jtb_pkg::IR_W-1:0]    ir_r;
  logic [jtb_pkg::BSR_W-1:0]   bsr_r;
  logic                        byp_r;
  jtb_pkg::jtb_upd_t           upd_r;
  logic                        tog_r;
  logic                        extest_lvl_r;
  logic                        tdo_r;
  logic                        tdo_oe_n_r;
  logic                        extest_sel;
  logic                        sample_sel;
  logic                        bypass_sel;
  logic [jtb_pkg::NUM_PINS-1:0] ibuf_en;
  jtb_pkg::jtb_xing_t          xs1_r;
  jtb_pkg::jtb_xing_t          xs2_r;
  jtb_pkg::jtb_xing_t          xs3_r;
  jtb_pkg::jtb_xing_t          xf_r;
  logic                        tog_seen_r;
  jtb_pkg::jtb_upd_t           upd_sys_r;
  logic                        extest_sys_r;
  logic [jtb_pkg::NUM_PINS-1:0] pin_o_r;
  logic [jtb_pkg::NUM_PINS-1:0] pin_oe_n_r;

  assign async_in = '{rst_n:      rst_n,
                      prog:       in_system_programming,
                      configured: configured,
                      force_ibuf: force_input_buffers,
                      out_only:   pin_output_only,
                      pin:        pin_i};

  // three-stage sync into tck; value accepted once stages two and three agree
  always_ff @(posedge tck) begin
    as1_r <= async_in;
    as2_r <= as1_r;
    as3_r <= as2_r;
  end

  always_ff @(posedge tck) begin
    for (int b = 0; b < $bits(jtb_pkg::jtb_async_t); b++) begin
      if (as2_r[b] == as3_r[b]) begin
        asf_r[b] <= as3_r[b];
      end
    end
  end

  // R03 reset derived from power-up reset only
  assign tck_rst = !asf_r.rst_n;

  // R10 pin-test codes fall back to bypass while programming
  assign extest_sel = (ir_r == jtb_pkg::IR_EXTEST) && !asf_r.prog;
  assign sample_sel = (ir_r == jtb_pkg::IR_SAMPLE) && !asf_r.prog;
  // R12 all-ones and any other code pick bypass
  assign bypass_sel = !(extest_sel || sample_sel);

  // R01 output-only pins gated off when configured
  // R02 force option overrides the gating
  assign ibuf_en = ~(asf_r.out_only
                     & {jtb_pkg::NUM_PINS{asf_r.configured
                                          & ~asf_r.force_ibuf}});

  // R13 controller steps on rising tck
  // R04 no control input can hold the port off
  always_ff @(posedge tck) begin
    if (tck_rst) begin
      st_r <= jtb_pkg::TLR;
    end else begin
      st_r <= jtb_pkg::tap_next(st_r, tms);
    end
  end

  // R06 capture the fixed pattern, shift lsb first
  always_ff @(posedge tck) begin
    if (tck_rst) begin
      ir_sr_r <= jtb_pkg::IR_CAPTURE;
    end else if (st_r == jtb_pkg::CAP_IR) begin
      ir_sr_r <= jtb_pkg::IR_CAPTURE;
    end else if (st_r == jtb_pkg::SH_IR) begin
      ir_sr_r <= {tdi, ir_sr_r[jtb_pkg::IR_W-1:1]};
    end
  end

  // R12 one-bit bypass stage
  always_ff @(posedge tck) begin
    if (tck_rst) begin
      byp_r <= 1'b0;
    end else if (st_r == jtb_pkg::CAP_DR) begin
      byp_r <= 1'b0;
    end else if (st_r == jtb_pkg::SH_DR) begin
      byp_r <= tdi;
    end
  end

  // R11 capture pin results and current update values
  always_ff @(posedge tck) begin
    if (tck_rst) begin
      bsr_r <= '0;
    end else if (st_r == jtb_pkg::CAP_DR && !bypass_sel) begin
      for (int i = 0; i < jtb_pkg::NUM_PINS; i++) begin
        bsr_r[i*jtb_pkg::CELL_W+jtb_pkg::CELL_IN]  <= asf_r.pin[i]
                                                      & ibuf_en[i];
        bsr_r[i*jtb_pkg::CELL_W+jtb_pkg::CELL_OUT] <= upd_r.out[i];
        bsr_r[i*jtb_pkg::CELL_W+jtb_pkg::CELL_OE]  <= upd_r.oe_n[i];
      end
    end else if (st_r == jtb_pkg::SH_DR && !bypass_sel) begin
      bsr_r <= {tdi, bsr_r[jtb_pkg::BSR_W-1:1]};
    end
  end

  // instruction and update registers change on falling tck
  always_ff @(negedge tck) begin
    if (tck_rst || st_r == jtb_pkg::TLR) begin
      ir_r <= jtb_pkg::IR_BYPASS;
    end else if (st_r == jtb_pkg::UPD_IR) begin
      ir_r <= ir_sr_r;
    end
  end

  always_ff @(negedge tck) begin
    if (tck_rst) begin
      upd_r <= '{oe_n: '1, out: '0};
      tog_r <= 1'b0;
    end else if (st_r == jtb_pkg::UPD_DR && !bypass_sel) begin
      for (int i = 0; i < jtb_pkg::NUM_PINS; i++) begin
        upd_r.out[i]  <= bsr_r[i*jtb_pkg::CELL_W+jtb_pkg::CELL_OUT];
        upd_r.oe_n[i] <= bsr_r[i*jtb_pkg::CELL_W+jtb_pkg::CELL_OE];
      end
      tog_r <= ~tog_r;
    end
  end

  always_ff @(negedge tck) begin
    if (tck_rst) begin
      extest_lvl_r <= 1'b0;
    end else begin
      extest_lvl_r <= extest_sel;
    end
  end

  // R12 tdo changes on the falling edge
  // R06 first shift-ir bit out before the next rising edge
  always_ff @(negedge tck) begin
    if (tck_rst) begin
      tdo_r      <= 1'b0;
      tdo_oe_n_r <= 1'b1;
    end else if (st_r == jtb_pkg::SH_IR) begin
      tdo_r      <= ir_sr_r[0];
      tdo_oe_n_r <= 1'b0;
    end else if (st_r == jtb_pkg::SH_DR) begin
      tdo_r      <= bypass_sel ? byp_r : bsr_r[0];
      tdo_oe_n_r <= 1'b0;
    end else begin
      tdo_oe_n_r <= 1'b1;
    end
  end

  // mode level and update toggle into clk_sys; words are stable by then
  always_ff @(posedge clk_sys) begin
    xs1_r <= '{extest: extest_lvl_r, tog: tog_r};
    xs2_r <= xs1_r;
    xs3_r <= xs2_r;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      xf_r <= '0;
    end else begin
      if (xs2_r.extest == xs3_r.extest) begin
        xf_r.extest <= xs3_r.extest;
      end
      if (xs2_r.tog == xs3_r.tog) begin
        xf_r.tog <= xs3_r.tog;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tog_seen_r   <= 1'b0;
      upd_sys_r    <= '{oe_n: '1, out: '0};
      extest_sys_r <= 1'b0;
    end else begin
      tog_seen_r   <= xf_r.tog;
      extest_sys_r <= xf_r.extest;
      if (xf_r.tog != tog_seen_r) begin
        upd_sys_r <= upd_r;
      end
    end
  end

  // R09 enable zero drives the update value
  // R11 extest takes pins from update registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_o_r    <= '0;
      pin_oe_n_r <= '1;
    end else if (extest_sys_r) begin
      pin_o_r    <= upd_sys_r.out;
      pin_oe_n_r <= upd_sys_r.oe_n;
    end else begin
      pin_o_r    <= core_out;
      pin_oe_n_r <= core_oe_n;
    end
  end
  assign tdo      = tdo_r;
  assign tdo_oe_n = tdo_oe_n_r;
  assign pin_o    = pin_o_r;
  assign pin_oe_n = pin_oe_n_r;
  sequence tms_high_run;
    tms [*5];
  endsequence
  sequence ir_entry;
    (st_r == jtb_pkg::TLR && !tms) ##1 tms ##1 tms ##1 !tms ##1 !tms;
  endsequence
  sequence bypass_two;
    (st_r == jtb_pkg::SH_DR && bypass_sel) ##1
    (st_r == jtb_pkg::SH_DR && bypass_sel);
  endsequence
  a_tms_reset_run: assert property ( // R13
    @(posedge tck) disable iff (tck_rst)
    tms_high_run |=> st_r == jtb_pkg::TLR)
    else $error("five tms highs did not reach reset");
  a_shift_ir_entry: assert property ( // R07
    @(posedge tck) disable iff (tck_rst)
    ir_entry |=> st_r == jtb_pkg::SH_IR)
    else $error("entry sequence did not reach shift-ir");
  a_ir_capture_val: assert property ( // R06
    @(posedge tck) disable iff (tck_rst)
    st_r == jtb_pkg::CAP_IR |=> ir_sr_r == jtb_pkg::IR_CAPTURE)
    else $error("instruction capture pattern wrong");
  a_ir_first_bit: assert property ( // R06
    @(posedge tck) disable iff (tck_rst)
    $rose(st_r == jtb_pkg::SH_IR) |->
      tdo_r == jtb_pkg::IR_CAPTURE[0] && !tdo_oe_n_r)
    else $error("first shift-ir bit not on tdo");
  a_bypass_path: assert property ( // R12
    @(posedge tck) disable iff (tck_rst)
    bypass_two |-> tdo_r == $past(tdi))
    else $error("bypass stage did not pass tdi to tdo");
  a_prog_no_update: assert property ( // R10
    @(posedge tck) disable iff (tck_rst)
    asf_r.prog && st_r == jtb_pkg::UPD_DR |=> $stable(upd_r))
    else $error("update registers changed during programming");
  a_ibuf_gate: assert property ( // R01
    @(posedge tck) disable iff (tck_rst)
    st_r == jtb_pkg::CAP_DR && !bypass_sel |=>
      jtb_pkg::bsr_inputs(bsr_r) == $past(asf_r.pin & ibuf_en))
    else $error("captured input ignores buffer gating");
  a_tap_powerup: assert property ( // R03
    @(posedge tck) disable iff (tck_rst)
    $fell(tck_rst) |-> st_r == jtb_pkg::TLR)
    else $error("controller not in reset after power-up");
  a_extest_drive: assert property ( // R09
    @(posedge clk_sys) disable iff (!rst_n)
    extest_sys_r |=> pin_o_r == $past(upd_sys_r.out)
                     && pin_oe_n_r == $past(upd_sys_r.oe_n))
    else $error("extest pins not from update registers");
endmodule
`default_nettype wire

// >>> jtb_master.sv
`timescale 1ns/1ns
`default_nettype none
module jtb_master (
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one 64 ns period; o is tdo as presented before the rising edge
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #16 o = tdo;
    tck = 1'b1;
    #32 tck = 1'b0;
    #15;
    // idle levels between frames, set apart from the next step
    tms = 1'b1;
    tdi = 1'b1;
    #1;
  endtask

  // shift n bits lsb first, then update and park in idle
  task automatic scan(input int n, input logic [11:0] din,
                      output logic [11:0] dout);
    logic o;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask

  task automatic ir(input logic [jtb_pkg::IR_W-1:0] code,
                    output logic [jtb_pkg::IR_W-1:0] cap);
    logic [11:0] v;
    logic        o;
    repeat (5) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b1, 1'b1, o);
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    scan(10, 12'(code), v);
    cap = v[9:0];
  endtask

  task automatic dr(input logic [11:0] din, output logic [11:0] dout);
    logic o;
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    scan(12, din, dout);
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic       clk_sys;
  logic       rst_n;
  logic       tck;
  logic       tms;
  logic       tdi;
  logic       tdo;
  logic       tdo_oe_n;
  logic       prog;
  logic       cfg;
  logic       frc;
  logic [3:0] only;
  logic [3:0] c_out;
  logic [3:0] c_oe_n;
  logic [3:0] p_i;
  logic [3:0] p_o;
  logic [3:0] p_oe_n;
  int         errors;
  int         cmp_count;

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  jtb_tap u_jtb_tap (
    .clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .in_system_programming(prog),
    .configured(cfg), .force_input_buffers(frc), .pin_output_only(only),
    .core_out(c_out), .core_oe_n(c_oe_n), .pin_i(p_i), .pin_o(p_o),
    .pin_oe_n(p_oe_n)
  );

  jtb_master u_jtb_master (
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo)
  );

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // cell order per pin: input, output value, output enable
  function automatic logic [11:0] pack(input logic [3:0] i,
                                       input logic [3:0] o,
                                       input logic [3:0] e);
    logic [11:0] b;
    for (int k = 0; k < 4; k++) begin
      b[3*k]   = i[k];
      b[3*k+1] = o[k];
      b[3*k+2] = e[k];
    end
    return b;
  endfunction

  task automatic drive(input logic s, input logic c, input logic f,
                       input logic [3:0] oo, input logic [3:0] pv);
    @(posedge clk_sys);
    #1;
    prog = s;
    cfg  = c;
    frc  = f;
    only = oo;
    p_i  = pv;
  endtask

  // only driven pins carry a defined value
  task automatic wait_pins(input logic [3:0] o, input logic [3:0] e);
    int n;
    n = 0;
    while (n < 64 && !((p_o & ~p_oe_n) === (o & ~e) && p_oe_n === e)) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(12'(p_oe_n), 12'(e));
    chk(12'(p_o & ~p_oe_n), 12'(o & ~e));
  endtask

  task automatic s_capture();
    logic [9:0] cap;
    u_jtb_master.ir(jtb_pkg::IR_SAMPLE, cap);
    chk(12'(cap), 12'h155);
    chk(12'(tdo_oe_n), 12'h001);
  endtask

  task automatic s_bypass();
    logic [9:0]  cap;
    logic [11:0] d;
    u_jtb_master.ir(jtb_pkg::IR_BYPASS, cap);
    u_jtb_master.dr(12'hB35, d);
    chk(d, 12'h66A);
  endtask

  task automatic s_extest();
    logic [9:0]  cap;
    logic [11:0] d;
    drive(1'b0, 1'b0, 1'b0, 4'h0, 4'h9);
    wait_pins(4'hA, 4'h0);
    u_jtb_master.ir(jtb_pkg::IR_SAMPLE, cap);
    u_jtb_master.dr(pack(4'h0, 4'h5, 4'h2), d);
    u_jtb_master.ir(jtb_pkg::IR_EXTEST, cap);
    wait_pins(4'h5, 4'h2);
    u_jtb_master.dr(pack(4'h0, 4'h3, 4'h0), d);
    chk(d, pack(4'h9, 4'h5, 4'h2));
    wait_pins(4'h3, 4'h0);
  endtask

  task automatic s_ibuf();
    logic [9:0]  cap;
    logic [11:0] d;
    drive(1'b0, 1'b1, 1'b0, 4'h3, 4'hF);
    u_jtb_master.ir(jtb_pkg::IR_SAMPLE, cap);
    u_jtb_master.dr(12'h000, d);
    chk(12'({d[9], d[6], d[3], d[0]}), 12'h00C);
    drive(1'b0, 1'b1, 1'b1, 4'h3, 4'hF);
    u_jtb_master.ir(jtb_pkg::IR_SAMPLE, cap);
    u_jtb_master.dr(12'h000, d);
    chk(12'({d[9], d[6], d[3], d[0]}), 12'h00F);
  endtask

  task automatic s_isp();
    logic [9:0]  cap;
    logic [11:0] d;
    drive(1'b1, 1'b0, 1'b0, 4'h0, 4'h9);
    u_jtb_master.ir(jtb_pkg::IR_EXTEST, cap);
    u_jtb_master.dr(12'hB35, d);
    chk(d, 12'h66A);
    wait_pins(4'hA, 4'h0);
    drive(1'b0, 1'b0, 1'b0, 4'h0, 4'h9);
  endtask

  initial begin
    logic o;
    errors    = 0;
    cmp_count = 0;
    rst_n     = 1'b0;
    prog      = 1'b0;
    cfg       = 1'b0;
    frc       = 1'b0;
    only      = 4'h0;
    p_i       = 4'h0;
    c_out     = 4'hA;
    c_oe_n    = 4'h0;
    @(posedge clk_sys);
    #1;
    // tck must run while reset is held so the scan side sees it
    repeat (8) u_jtb_master.step(1'b1, 1'b1, o);
    @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (10) u_jtb_master.step(1'b1, 1'b1, o);
    s_capture();
    s_bypass();
    s_extest();
    s_ibuf();
    s_isp();
    test_done();
  end
endmodule
`default_nettype wire
